// *** pad_ring_model.sv ***
// port pins standing beyond the waveform outputs
// assumes pins with a weak pull-up when their direction is input
`timescale 1ns/1ps
module pad_ring_model (
	input  wire logic [2:0] wave_out,
	input  wire logic [2:0] wave_oe,
	input  wire logic [2:0] port_value,
	input  wire logic [2:0] port_dir,
	output logic      [2:0] pad_level
);
	// input pins float to the pull-up, never the last driven value
	assign pad_level = ~port_dir
		| (port_dir & ((wave_oe & wave_out) | (~wave_oe & port_value)));
endmodule

// *** test_timer_control_buffer_logic.sv ***
// self-checking bench for the timer control and buffer logic
// assumes one apb wait state, ce held high and all pins set as outputs
`timescale 1ns/1ps
module test_timer_control_buffer_logic;
	import tmr_ctrl_pkg::*;
	logic        sys_clk, rst, psel, penable, pwrite, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, split_mode, overflow_pulse;
	logic [2:0]  wave_out, wave_oe, block_out, pad_level;
	int          errors, tests_run;

	tmr_ctrl dut (.SYS_CLK(sys_clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .WAVE_PIN_OUT(wave_out), .WAVE_PIN_OE(wave_oe),
		.LOGIC_BLOCK_OUT(block_out), .OVERFLOW_PULSE(overflow_pulse), .SPLIT_MODE(split_mode));
	pad_ring_model pads (.wave_out(wave_out), .wave_oe(wave_oe), .port_value(3'b010),
		.port_dir(3'b111), .pad_level(pad_level));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// idle edge so a following setup never re-drives psel in this step
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rdchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		check(name, rd, exp);
	endtask

	task automatic wait_ovf(output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (overflow_pulse !== 1'b1 && n < 100);
	endtask

	task automatic t_reset;
		for (int i = 2; i < 8; i++) begin
			rdchk("ctrl reset", 6'(i), 32'h0);
		end
		rdchk("cycle len reset", IDX_CYCLE_LENGTH, 32'hffff);
		apb(1'b0, 6'h08, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
		check("unmapped data", rd, 32'h0);
	endtask

	task automatic t_pairs;
		wr(IDX_CMD_LOCK_SET, 32'h3);
		rdchk("set pair", IDX_CMD_LOCK_CLEAR, 32'h3);
		wr(IDX_CMD_LOCK_CLEAR, 32'h1);
		rdchk("clear dir", IDX_CMD_LOCK_SET, 32'h2);
		wr(IDX_CMD_LOCK_CLEAR, 32'h0);
		rdchk("zeros keep", IDX_CMD_LOCK_SET, 32'h2);
		wr(IDX_CMD_LOCK_SET, 32'h8);
		rdchk("cmd reads zero", IDX_CMD_LOCK_SET, 32'h2);
	endtask

	// lock is still set here, so only the command may load
	task automatic t_forced;
		wr(IDX_COMPARE_BUF_0, 32'h1234);
		rdchk("cmp bv set", IDX_BUF_VALID_SET, 32'h2);
		wr(IDX_CYCLE_LENGTH_BUF, 32'h40);
		rdchk("cyc bv set", IDX_BUF_VALID_CLEAR, 32'h3);
		wr(IDX_CMD_LOCK_SET, 32'h4);
		rdchk("forced cmp0", IDX_COMPARE_0, 32'h1234);
		rdchk("forced cyc", IDX_CYCLE_LENGTH, 32'h40);
		rdchk("bv cleared", IDX_BUF_VALID_SET, 32'h0);
		rdchk("cmp1 kept", IDX_COMPARE_1, 32'h0);
		wr(IDX_CMD_LOCK_CLEAR, 32'h2);
	endtask

	task automatic t_modes;
		logic [2:0] md [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
		int         cycle_length [4] = '{4, 6, 3, 6};
		int         n;
		wr(IDX_CYCLE_LENGTH, 32'h3);
		wr(IDX_RUN_CONTROL, 32'h1);
		wait_ovf(n);
		wait_ovf(n);
		check("normal period", n, 4);
		wr(IDX_COMPARE_0, 32'h5);
		wr(IDX_WAVEFORM_CONTROL, 32'h1);
		wait_ovf(n);
		wait_ovf(n);
		check("freq period", n, 6);
		wr(IDX_COMPARE_BUF_0, 32'h2);
		wait_ovf(n);
		rdchk("unlocked load", IDX_COMPARE_0, 32'h2);
		rdchk("bv after load", IDX_BUF_VALID_SET, 32'h0);
		wait_ovf(n);
		wait_ovf(n);
		check("new freq period", n, 3);
		for (int i = 0; i < 4; i++) begin
			wr(IDX_WAVEFORM_CONTROL, {29'h0, md[i]});
			wait_ovf(n);
			wait_ovf(n);
			wait_ovf(n);
			check("mode period", n, cycle_length[i]);
		end
		wr(IDX_RUN_CONTROL, 32'h0);
		wr(IDX_CMD_LOCK_SET, 32'h8);
	endtask

	task automatic t_autolock;
		int n;
		wr(IDX_BUF_VALID_CLEAR, 32'hf);
		wr(IDX_WAVEFORM_CONTROL, 32'h18);
		rdchk("auto lock held", IDX_CMD_LOCK_SET, 32'h2);
		wr(IDX_COMPARE_BUF_0, 32'h7);
		rdchk("auto lock free", IDX_CMD_LOCK_SET, 32'h0);
		wr(IDX_RUN_CONTROL, 32'h1);
		wait_ovf(n);
		wr(IDX_RUN_CONTROL, 32'h0);
		rdchk("auto loaded", IDX_COMPARE_0, 32'h7);
		rdchk("auto relocked", IDX_CMD_LOCK_SET, 32'h2);
		wr(IDX_WAVEFORM_CONTROL, 32'h0);
		wr(IDX_CMD_LOCK_CLEAR, 32'h2);
		rdchk("manual clear", IDX_CMD_LOCK_SET, 32'h0);
		wr(IDX_CMD_LOCK_SET, 32'h2);
		rdchk("manual set", IDX_CMD_LOCK_SET, 32'h2);
		wr(IDX_CMD_LOCK_CLEAR, 32'h2);
	endtask

	task automatic t_pins;
		wr(IDX_WAVEFORM_CONTROL, 32'h11);
		wr(IDX_OUTPUT_VALUE_CTRL, 32'h5);
		repeat (3) @(posedge sys_clk);
		check("block out", {29'h0, block_out}, 32'h5);
		check("pin oe", {29'h0, wave_oe}, 32'h1);
		check("pad level", {29'h0, pad_level}, 32'h3);
		wr(IDX_WAVEFORM_CONTROL, 32'h70);
		wr(IDX_RUN_CONTROL, 32'h1);
		repeat (3) @(posedge sys_clk);
		check("normal no oe", {29'h0, wave_oe}, 32'h0);
		wr(IDX_WAVEFORM_CONTROL, 32'h73);
		repeat (3) @(posedge sys_clk);
		check("pwm oe", {29'h0, wave_oe}, 32'h7);
		wr(IDX_SPLIT_CONTROL, 32'h1);
		check("split on", {31'h0, split_mode}, 32'h1);
		wr(IDX_SPLIT_CONTROL, 32'h0);
		check("split off", {31'h0, split_mode}, 32'h0);
	endtask

	// hard reset must be refused while running
	task automatic t_hard;
		wr(IDX_CMD_LOCK_SET, 32'hc);
		rdchk("hard ignored", IDX_OUTPUT_VALUE_CTRL, 32'h5);
		wr(IDX_RUN_CONTROL, 32'h0);
		wr(IDX_CMD_LOCK_SET, 32'hc);
		rdchk("hard out val", IDX_OUTPUT_VALUE_CTRL, 32'h0);
		rdchk("hard cyc len", IDX_CYCLE_LENGTH, 32'hffff);
	endtask

	task automatic tally_and_finish;
		if (errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#300us;
		errors++;
		tally_and_finish;
	end

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		errors = 0;
		tests_run = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_reset;
		t_pairs;
		t_forced;
		t_modes;
		t_autolock;
		t_pins;
		t_hard;
		tally_and_finish;
	end
endmodule

// *** tmr_ctrl.sv ***
// timer control, buffer and waveform output routing for a 16-bit timer
// assumes an apb master on SYS_CLK; pads and logic block sit on the same clock
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

// Summary of operation
// [R1] - enable bit routes waveform over port value
// [R2] - software sets pin direction to output
// [R3] - auto-lock holds lock until enabled buffers valid
// [R4] - lock cleared until update, then set again
// [R5] - without auto-lock, only software changes lock
// [R6] - mode field picks operation and top value
// [R7] - mode picks update and overflow points
// [R8] - normal mode no waveform; pins need enable
// [R9] - stopped timer: software writes output values directly
// [R10] - direct values need enable for pad, not logic block
// [R11] - split bit selects two 8-bit timers; here it only halts the 16-bit counter and drives SPLIT_MODE
// [R12] - clear/set register pairs act on ones
// [R13] - command field: update, restart, hard reset
// [R14] - command field always reads zero
// [R15] - unlocked update loads buffers immediately
// [R16] - locked update blocked, forced update still loads
// [R17] - direction bit: zero up, one down
// [R18] - compare buffer valid set on write, cleared on update
// [R19] - cycle length buffer valid likewise
// [R20] - update copies only valid buffers
module tmr_ctrl (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic      [2:0]  WAVE_PIN_OUT,
	output logic      [2:0]  WAVE_PIN_OE,
	output logic      [2:0]  LOGIC_BLOCK_OUT,
	output logic             OVERFLOW_PULSE,
	output logic             SPLIT_MODE
);
	import tmr_ctrl_pkg::*;
	function automatic logic idx_mapped(input logic [5:0] i);
		case (i)
			IDX_RUN_CONTROL, IDX_WAVEFORM_CONTROL, IDX_OUTPUT_VALUE_CTRL,
			IDX_SPLIT_CONTROL, IDX_CMD_LOCK_CLEAR, IDX_CMD_LOCK_SET,
			IDX_BUF_VALID_CLEAR, IDX_BUF_VALID_SET, IDX_COUNT,
			IDX_CYCLE_LENGTH, IDX_COMPARE_0, IDX_COMPARE_1, IDX_COMPARE_2,
			IDX_CYCLE_LENGTH_BUF, IDX_COMPARE_BUF_0, IDX_COMPARE_BUF_1,
			IDX_COMPARE_BUF_2: idx_mapped = 1'b1;
			default: idx_mapped = 1'b0;
		endcase
	endfunction
	logic        enable_r, enable_nxt;
	logic [7:0]  wfctl_r, wfctl_nxt;
	logic [2:0]  outval_r, outval_nxt;
	logic        split_r, split_nxt;
	logic        lock_r, lock_nxt;
	logic        dir_r, dir_nxt;
	logic        cyc_bv_r, cyc_bv_nxt;
	logic [2:0]  cmp_bv_r, cmp_bv_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [15:0] cyc_r, cyc_nxt;
	logic [15:0] cyc_buf_r, cyc_buf_nxt;
	logic [15:0] cmp_r [3];
	logic [15:0] cmp_nxt [3];
	logic [15:0] cmp_buf_r [3];
	logic [15:0] cmp_buf_nxt [3];
	logic [2:0]  wg_r, wg_nxt;
	logic        pready_r;
	logic [31:0] prdata_r, rd_word;
	logic        pslverr_r;
	// bus decode: one wait state so read data can come from a flop
	wire        access   = PSEL & PENABLE & pready_r;
	wire        wr       = access & PWRITE;
	wire [5:0]  idx      = PADDR[7:2];
	wire        bad_addr = (PADDR[1:0] != 2'b00) | ~idx_mapped(idx);
	wire        wr_ok    = wr & ~bad_addr;
	wire [7:0]  wd8      = PWDATA[7:0];
	wire [15:0] wd16     = PWDATA[15:0];
	wire        wr_eclr  = wr_ok & (idx == IDX_CMD_LOCK_CLEAR);
	wire        wr_eset  = wr_ok & (idx == IDX_CMD_LOCK_SET);
	wire        wr_fclr  = wr_ok & (idx == IDX_BUF_VALID_CLEAR);
	wire        wr_fset  = wr_ok & (idx == IDX_BUF_VALID_SET);
	wire [1:0]  cmd_raw  = wd8[CMDL_CMD_LSB +: 2];
	wire        cmd_wr   = wr_eclr | wr_eset;
	wire        wr_wfctl = wr_ok & (idx == IDX_WAVEFORM_CONTROL);
	// both halves of the pair execute the command [R13]
	wire force_upd = cmd_wr & (cmd_raw == CMD_UPDATE);
	wire restart   = cmd_wr & (cmd_raw == CMD_RESTART);
	wire hard_rst  = cmd_wr & (cmd_raw == CMD_HARD) & ~enable_r;
	wave_mode_t mode;
	assign mode = wave_mode_t'(wfctl_r[WF_MODE_LSB +: 3]);
	wire [2:0]  cmp_en    = wfctl_r[WF_CMP_EN_LSB +: 3];
	wire        auto_lock = wfctl_r[WF_AUTO_LOCK_BIT];
	wire        up_top    = (mode == MODE_NORMAL) | (mode == MODE_FREQUENCY);
	wire        two_ramp  = mode[2] & mode[0] | (mode == MODE_TWO_RAMP_OVF_BOTH);
	wire [15:0] top       = (mode == MODE_FREQUENCY) ? cmp_r[0] : cyc_r; // [R6]
	wire        tick      = enable_r & ~split_r;
	wire        at_top    = cnt_r == top;
	wire        at_bot    = cnt_r == 16'h0000;
	wire        lock_arm  = wr_wfctl & wd8[WF_AUTO_LOCK_BIT] & ~auto_lock; // [R3]
	// update and overflow points [R7]
	wire upd_cond = tick & (up_top ? (at_top & ~dir_r) : at_bot);
	wire ovf_cond = tick & ((mode == MODE_TWO_RAMP_OVF_HI)   ? at_top :
	                       (mode == MODE_TWO_RAMP_OVF_BOTH) ? (at_top | at_bot) :
	                       up_top ? (at_top & ~dir_r) : at_bot);
	// locked update never loads, forced one always does [R15] [R16]
	wire load      = (upd_cond & ~lock_r) | force_upd;
	wire all_valid = &(cmp_bv_r | ~cmp_en);
	// control, lock and direction next state
	always_comb begin
		enable_nxt = enable_r;
		wfctl_nxt  = wfctl_r;
		outval_nxt = outval_r;
		split_nxt  = split_r;
		lock_nxt   = lock_r;
		dir_nxt    = dir_r;
		if (wr_ok & (idx == IDX_RUN_CONTROL))
			enable_nxt = wd8[RUN_ENABLE_BIT];
		if (wr_ok & (idx == IDX_WAVEFORM_CONTROL))
			wfctl_nxt = {1'b0, wd8[6:0]};
		if (wr_ok & (idx == IDX_OUTPUT_VALUE_CTRL))
			outval_nxt = wd8[2:0];
		if (wr_ok & (idx == IDX_SPLIT_CONTROL))
			split_nxt = wd8[SPLIT_MODE_BIT]; // [R11]
		if (tick & two_ramp & at_top & ~dir_r)
			dir_nxt = 1'b1; // [R17]
		else if (tick & two_ramp & at_bot & dir_r)
			dir_nxt = 1'b0; // [R17]
		if (restart)
			dir_nxt = 1'b0;
		// ones act, zeros leave the bit alone [R12]
		if (wr_eclr & wd8[CMDL_DIR_BIT])
			dir_nxt = 1'b0; // [R17]
		if (wr_eset & wd8[CMDL_DIR_BIT])
			dir_nxt = 1'b1; // [R17]
		if (wr_eclr & wd8[CMDL_LOCK_BIT])
			lock_nxt = 1'b0; // [R12]
		if (wr_eset & wd8[CMDL_LOCK_BIT])
			lock_nxt = 1'b1; // [R12]
		// without auto-lock only the writes above, lock_arm and a hard reset touch it [R5]
		if (auto_lock) begin
			if (upd_cond & ~lock_r)
				lock_nxt = 1'b1; // [R4]
			else if (lock_r & all_valid)
				lock_nxt = 1'b0; // [R3]
		end
		if (lock_arm)
			lock_nxt = 1'b1; // [R3]
		if (hard_rst) begin
			enable_nxt = 1'b0;
			wfctl_nxt  = CTRL_RESET;
			outval_nxt = 3'b000;
			split_nxt  = 1'b0;
			lock_nxt   = 1'b0;
			dir_nxt    = 1'b0;
		end
	end
	// buffers, valid flags and counter; a write beats a same-cycle clear
	always_comb begin
		cyc_nxt     = cyc_r;
		cyc_buf_nxt = cyc_buf_r;
		cyc_bv_nxt  = cyc_bv_r;
		cmp_bv_nxt  = cmp_bv_r;
		cnt_nxt     = cnt_r;
		cmp_nxt     = cmp_r;
		cmp_buf_nxt = cmp_buf_r;
		if (tick) begin
			if (two_ramp)
				cnt_nxt = dir_r ? (at_bot ? 16'h0001 : cnt_r - 16'h0001)
				                : (at_top ? cnt_r - 16'h0001 : cnt_r + 16'h0001);
			else if (dir_r)
				cnt_nxt = at_bot ? top : cnt_r - 16'h0001;
			else
				cnt_nxt = at_top ? 16'h0000 : cnt_r + 16'h0001;
		end
		if (load) begin
			if (cyc_bv_r)
				cyc_nxt = cyc_buf_r; // [R20]
			for (int n = 0; n < 3; n++)
				if (cmp_bv_r[n])
					cmp_nxt[n] = cmp_buf_r[n]; // [R20]
			cyc_bv_nxt = 1'b0; // [R19]
			cmp_bv_nxt = 3'b000; // [R18]
		end
		if (wr_fclr) begin
			cyc_bv_nxt = cyc_bv_nxt & ~wd8[BV_CYCLE_BIT]; // [R12]
			cmp_bv_nxt = cmp_bv_nxt & ~wd8[BV_CMP_LSB +: 3]; // [R12]
		end
		if (wr_fset) begin
			cyc_bv_nxt = cyc_bv_nxt | wd8[BV_CYCLE_BIT];
			cmp_bv_nxt = cmp_bv_nxt | wd8[BV_CMP_LSB +: 3];
		end
		if (wr_ok & (idx == IDX_COUNT))
			cnt_nxt = wd16;
		if (wr_ok & (idx == IDX_CYCLE_LENGTH))
			cyc_nxt = wd16;
		if (wr_ok & (idx == IDX_CYCLE_LENGTH_BUF)) begin
			cyc_buf_nxt = wd16;
			cyc_bv_nxt  = 1'b1; // [R19]
		end
		for (int n = 0; n < 3; n++) begin
			if (wr_ok & (idx == IDX_COMPARE_0 + 6'(2 * n)))
				cmp_nxt[n] = wd16;
			if (wr_ok & (idx == IDX_COMPARE_BUF_0 + 6'(2 * n))) begin
				cmp_buf_nxt[n] = wd16;
				cmp_bv_nxt[n]  = 1'b1; // [R18]
			end
		end
		if (restart)
			cnt_nxt = 16'h0000;
		if (hard_rst) begin
			cnt_nxt     = WORD_RESET;
			cyc_nxt     = CYCLE_LEN_RESET;
			cyc_buf_nxt = CYCLE_LEN_RESET;
			cyc_bv_nxt  = 1'b0;
			cmp_bv_nxt  = 3'b000;
			cmp_nxt     = '{default: WORD_RESET};
			cmp_buf_nxt = '{default: WORD_RESET};
		end
	end
	// waveform generator; stopped timer shows the written values [R9]
	always_comb begin
		wg_nxt = wg_r;
		for (int n = 0; n < 3; n++) begin
			if (!enable_r)
				wg_nxt[n] = outval_r[n]; // [R9]
			else if (tick & (cnt_r == cmp_r[n])) begin
				case (mode)
					MODE_FREQUENCY:       wg_nxt[n] = ~wg_r[n];
					MODE_ONE_RAMP_PWM:    wg_nxt[n] = 1'b0;
					MODE_TWO_RAMP_OVF_HI,
					MODE_TWO_RAMP_OVF_BOTH,
					MODE_TWO_RAMP_OVF_LO: wg_nxt[n] = dir_r;
					default:              wg_nxt[n] = wg_r[n]; // [R8]
				endcase
			end else if (tick & (mode == MODE_ONE_RAMP_PWM) & at_bot)
				wg_nxt[n] = 1'b1;
		end
		if (restart | hard_rst)
			wg_nxt = 3'b000;
	end
	// read mux; command field is never stored so it reads zero [R14]
	always_comb begin
		rd_word = 32'h0000_0000;
		case (idx)
			IDX_RUN_CONTROL:       rd_word[0]    = enable_r;
			IDX_WAVEFORM_CONTROL:  rd_word[7:0]  = wfctl_r;
			IDX_OUTPUT_VALUE_CTRL: rd_word[2:0]  = outval_r;
			IDX_SPLIT_CONTROL:     rd_word[0]    = split_r;
			IDX_CMD_LOCK_CLEAR,
			IDX_CMD_LOCK_SET:      rd_word[1:0]  = {lock_r, dir_r}; // [R14]
			IDX_BUF_VALID_CLEAR,
			IDX_BUF_VALID_SET:     rd_word[3:0]  = {cmp_bv_r, cyc_bv_r};
			IDX_COUNT:             rd_word[15:0] = cnt_r;
			IDX_CYCLE_LENGTH:      rd_word[15:0] = cyc_r;
			IDX_COMPARE_0:         rd_word[15:0] = cmp_r[0];
			IDX_COMPARE_1:         rd_word[15:0] = cmp_r[1];
			IDX_COMPARE_2:         rd_word[15:0] = cmp_r[2];
			IDX_CYCLE_LENGTH_BUF:  rd_word[15:0] = cyc_buf_r;
			IDX_COMPARE_BUF_0:     rd_word[15:0] = cmp_buf_r[0];
			IDX_COMPARE_BUF_1:     rd_word[15:0] = cmp_buf_r[1];
			IDX_COMPARE_BUF_2:     rd_word[15:0] = cmp_buf_r[2];
			default:               rd_word       = 32'h0000_0000;
		endcase
		if (bad_addr)
			rd_word = 32'h0000_0000;
	end
	// pads need the enable and a generating mode or a stopped timer [R1] [R10]
	wire [2:0] pad_oe = cmp_en & {3{(mode != MODE_NORMAL) | ~enable_r}};
	// bus handshake; CE low stalls the bus too
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (CE) begin
			pready_r  <= PSEL & PENABLE & ~pready_r;
			prdata_r  <= rd_word;
			pslverr_r <= PSEL & PENABLE & ~pready_r & bad_addr;
		end
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			enable_r  <= 1'b0;
			wfctl_r   <= CTRL_RESET;
			outval_r  <= 3'b000;
			split_r   <= 1'b0;
			lock_r    <= 1'b0;
			dir_r     <= 1'b0;
			cyc_bv_r  <= 1'b0;
			cmp_bv_r  <= 3'b000;
			cnt_r     <= WORD_RESET;
			cyc_r     <= CYCLE_LEN_RESET;
			cyc_buf_r <= CYCLE_LEN_RESET;
			wg_r      <= 3'b000;
			cmp_r     <= '{default: WORD_RESET};
			cmp_buf_r <= '{default: WORD_RESET};
		end else if (CE) begin
			enable_r  <= enable_nxt;
			wfctl_r   <= wfctl_nxt;
			outval_r  <= outval_nxt;
			split_r   <= split_nxt;
			lock_r    <= lock_nxt;
			dir_r     <= dir_nxt;
			cyc_bv_r  <= cyc_bv_nxt;
			cmp_bv_r  <= cmp_bv_nxt;
			cnt_r     <= cnt_nxt;
			cyc_r     <= cyc_nxt;
			cyc_buf_r <= cyc_buf_nxt;
			wg_r      <= wg_nxt;
			cmp_r     <= cmp_nxt;
			cmp_buf_r <= cmp_buf_nxt;
		end
	end
	// pin stage costs one cycle of lag, traded for flop-driven pads
	logic [2:0] pin_out_r, pin_oe_r;
	logic       ovf_r;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			pin_out_r <= 3'b000;
			pin_oe_r  <= 3'b000;
			ovf_r     <= 1'b0;
		end else if (CE) begin
			pin_out_r <= wg_r & pad_oe; // [R1] [R8]
			pin_oe_r  <= pad_oe; // [R1] [R10]
			ovf_r     <= ovf_cond; // [R7]
		end
	end
	assign PRDATA          = prdata_r;
	assign PREADY          = pready_r;
	assign PSLVERR         = pslverr_r;
	assign WAVE_PIN_OUT    = pin_out_r;
	assign WAVE_PIN_OE     = pin_oe_r;
	assign LOGIC_BLOCK_OUT = wg_r; // enable bypassed toward logic block [R10]
	assign OVERFLOW_PULSE  = ovf_r;
	assign SPLIT_MODE      = split_r; // [R11]
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	wire rd_e = PREADY & ~PWRITE & ((idx == IDX_CMD_LOCK_CLEAR) | (idx == IDX_CMD_LOCK_SET));
	a_cmd_reads_zero: assert property (rd_e |-> PRDATA[3:2] == 2'b00) // [R14]
		else $error("command field read back nonzero");
	a_lock_software_only: assert property (CE & ~auto_lock & ~cmd_wr & ~lock_arm // [R5]
		|=> $stable(lock_r))
		else $error("lock changed without software write");
	a_lock_release: assert property (CE & auto_lock & lock_r & all_valid & ~cmd_wr
		|=> !lock_r) // [R3]
		else $error("auto-lock did not release");
	a_lock_reset_upd: assert property (CE & auto_lock & ~lock_r & upd_cond & ~cmd_wr
		|=> lock_r) // [R4]
		else $error("auto-lock not set again at update");
	a_locked_no_load: assert property (CE & lock_r & upd_cond & ~cmd_wr & ~wr
		|=> $stable(cyc_r) && $stable(cmp_bv_r)) // [R16]
		else $error("locked update loaded buffers");
	a_force_loads: assert property (CE & force_upd & cyc_bv_r & ~wr_fset
		|=> cyc_r == $past(cyc_buf_r) && !cyc_bv_r) // [R16]
		else $error("forced update did not load");
	a_pad_gate: assert property (CE & ~cmp_en[0] |=> !WAVE_PIN_OE[0] ##1 1) // [R1]
		else $error("pad driven without enable");
	a_direct_value: assert property (CE & ~enable_r & ~cmd_wr |=> wg_r == $past(outval_r)) // [R9]
		else $error("stopped output not the written value");
	a_hard_ignored: assert property (CE & cmd_wr & (cmd_raw == CMD_HARD) & enable_r
		|=> enable_r && $stable(wfctl_r)) // [R13]
		else $error("hard reset acted while enabled");
endmodule

// *** tmr_ctrl_pkg.sv ***
// constants for the timer control and buffer logic
// assumes a 32-bit apb slave; each register sits at byte address 4 * index
package tmr_ctrl_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_RUN_CONTROL       = 6'h00;
	localparam logic [5:0] IDX_WAVEFORM_CONTROL  = 6'h01;
	localparam logic [5:0] IDX_OUTPUT_VALUE_CTRL = 6'h02;
	localparam logic [5:0] IDX_SPLIT_CONTROL     = 6'h03;
	localparam logic [5:0] IDX_CMD_LOCK_CLEAR    = 6'h04;
	localparam logic [5:0] IDX_CMD_LOCK_SET      = 6'h05;
	localparam logic [5:0] IDX_BUF_VALID_CLEAR   = 6'h06;
	localparam logic [5:0] IDX_BUF_VALID_SET     = 6'h07;
	localparam logic [5:0] IDX_COUNT             = 6'h20;
	localparam logic [5:0] IDX_CYCLE_LENGTH      = 6'h26;
	localparam logic [5:0] IDX_COMPARE_0         = 6'h28;
	localparam logic [5:0] IDX_COMPARE_1         = 6'h2a;
	localparam logic [5:0] IDX_COMPARE_2         = 6'h2c;
	localparam logic [5:0] IDX_CYCLE_LENGTH_BUF  = 6'h36;
	localparam logic [5:0] IDX_COMPARE_BUF_0     = 6'h38;
	localparam logic [5:0] IDX_COMPARE_BUF_1     = 6'h3a;
	localparam logic [5:0] IDX_COMPARE_BUF_2     = 6'h3c;

	// field positions
	localparam int RUN_ENABLE_BIT    = 0;
	localparam int WF_MODE_LSB       = 0;
	localparam int WF_AUTO_LOCK_BIT  = 3;
	localparam int WF_CMP_EN_LSB     = 4;
	localparam int SPLIT_MODE_BIT    = 0;
	localparam int CMDL_DIR_BIT      = 0;
	localparam int CMDL_LOCK_BIT     = 1;
	localparam int CMDL_CMD_LSB      = 2;
	localparam int BV_CYCLE_BIT      = 0;
	localparam int BV_CMP_LSB        = 1;

	// reset values
	localparam logic [7:0]  CTRL_RESET        = 8'h00;
	localparam logic [15:0] CYCLE_LEN_RESET   = 16'hffff;
	localparam logic [15:0] WORD_RESET        = 16'h0000;

	typedef enum logic [2:0] {
		MODE_NORMAL           = 3'b000,
		MODE_FREQUENCY        = 3'b001,
		MODE_RESERVED_2       = 3'b010,
		MODE_ONE_RAMP_PWM     = 3'b011,
		MODE_RESERVED_4       = 3'b100,
		MODE_TWO_RAMP_OVF_HI  = 3'b101,
		MODE_TWO_RAMP_OVF_BOTH= 3'b110,
		MODE_TWO_RAMP_OVF_LO  = 3'b111
	} wave_mode_t;

	typedef enum logic [1:0] {
		CMD_NONE    = 2'b00,
		CMD_UPDATE  = 2'b01,
		CMD_RESTART = 2'b10,
		CMD_HARD    = 2'b11
	} command_t;

endpackage
